// >>> smid_top.sv
// Operation
// - with status type select 0 the answer holds zeros in D7:D4 and the four channel current flags in D3:D0.
// - the channel current flags are captured when chip select falls.
// - the identity answer echoes the header and carries the device code in D9:D6 and revision in D5:D0.
// - D13 of every frame makes the 16 bits odd parity; commands are checked, answers generated.
// - status type select D9 picks current flags (0) or fire permit flags (1) for D7:D0.
// - D8 of the status answer reads 0 after reset and 1 afterwards, cleared by being read.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module smid_top
	import smid_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	input wire logic [CHANNELS-1:0] current_threshold,
	input wire logic [1:0] fire_permit
);
	// ------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------
	// every link and flag pin passes two flops before any logic reads it; the link is
	// slow against pclk, so the two-cycle lag only shifts the frame edges
	localparam int SW = 3 + CHANNELS + 2;
	logic [SW-1:0] pins_s;
	smid_sync #(.W(SW)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({spi_sck, ~spi_cs_n, spi_mosi, current_threshold, fire_permit}),
		.q(pins_s)
	);
	wire sck_s = pins_s[SW-1];
	// chip select travels inverted, so the synchroniser's cleared state
	// matches the idle pin and no false frame start follows a reset
	wire cs_n_s = ~pins_s[SW-2];
	wire mosi_s = pins_s[SW-3];
	wire [CHANNELS-1:0] cur_s = pins_s[SW-4 -: CHANNELS];
	wire [1:0] fire_s = pins_s[1:0];

	logic sck_q, cs_n_q;
	smid_state_type state_q, state_d;
	logic [FRAME_W-1:0] rx_q, tx_q, last_cmd_q;
	logic [4:0] cnt_q;
	// the answer shift register itself is the frame-start snapshot
	logic reset_seen_n_q; // 0 until a status answer reported the reset
	logic [IRQ_W-1:0] irq_st_q, irq_mask_q;
	logic miso_q;

	// ------------------------------------------------------------
	// edge detection on the sampled link
	// ------------------------------------------------------------
	wire sck_rise = sck_s & ~sck_q;
	wire sck_fall = ~sck_s & sck_q;
	wire cs_fall = ~cs_n_s & cs_n_q;
	wire cs_rise = cs_n_s & ~cs_n_q;
	wire [FRAME_W-1:0] rx_next = {rx_q[FRAME_W-2:0], mosi_s};
	// counting only while shifting keeps a stray sck edge between frames
	// from posting a command
	wire frame_full = (state_q == SMID_SHIFT) & sck_rise
		& (cnt_q == 5'(FRAME_W - 1));

	// ------------------------------------------------------------
	// answer building for the previous command
	// ------------------------------------------------------------
	// every frame shifts out the answer to the last complete frame before it; a rejected
	// command, or none since reset, answers with the error frame, which
	// already holds odd parity
	wire [1:0] cmd_mode = last_cmd_q[BIT_SEL_HI:BIT_SEL_LO];
	wire cmd_head = last_cmd_q[BIT_MODE_HI] & last_cmd_q[BIT_MODE_LO]
		& ~last_cmd_q[BIT_CLR];
	wire cmd_type = last_cmd_q[BIT_TYPE_SEL];
	// flags are taken live: the answer is loaded at the chip select fall,
	// so what lands in tx_q is the value at frame start
	wire [7:0] cur_field = {4'h0, cur_s};
	wire [7:0] fire_field = {6'h00, fire_s};
	wire [7:0] stat_low = cmd_type ? fire_field : cur_field;
	wire [FRAME_W-1:0] stat_raw = {2'h3, 1'b0, 1'b0, MON_STATUS, cmd_type,
		reset_seen_n_q, stat_low};
	wire [FRAME_W-1:0] ident_raw = {2'h3, 1'b0, 1'b0, MON_IDENT,
		DEVICE_CODE, REVISION};
	wire is_stat = cmd_head & (cmd_mode == MON_STATUS);
	wire is_ident = cmd_head & (cmd_mode == MON_IDENT);
	wire [FRAME_W-1:0] raw = is_stat ? stat_raw :
		(is_ident ? ident_raw : ERR_FRAME);
	// parity slot is zero in raw, so the inverted xor of raw gives the fix
	wire [FRAME_W-1:0] answer = raw |
		({{(FRAME_W-1){1'b0}}, ~smid_odd_ok(raw)} << BIT_PARITY);

	// command check once the frame is complete
	wire par_ok = smid_odd_ok(rx_next);
	wire hdr_ok = rx_next[BIT_MODE_HI] & rx_next[BIT_MODE_LO]
		& ~rx_next[BIT_CLR];
	wire id_ok = hdr_ok & (rx_next[BIT_SEL_HI:BIT_SEL_LO] == MON_IDENT)
		& (rx_next[BIT_TYPE_SEL:0] == 10'h000);
	wire st_ok = hdr_ok & (rx_next[BIT_SEL_HI:BIT_SEL_LO] == MON_STATUS)
		& (rx_next[BIT_RESET_SEEN:0] == 9'h000);
	wire cmd_ok = par_ok & (id_ok | st_ok);

	// ------------------------------------------------------------
	// frame state machine
	// ------------------------------------------------------------
	// a frame cut short by chip select returns to idle at once; the
	// command of a cut frame is never posted
	always_comb begin
		state_d = state_q;
		case (state_q)
			SMID_IDLE: if (cs_fall) state_d = SMID_SHIFT;
			SMID_SHIFT: begin
				if (cs_rise) state_d = SMID_IDLE;
				else if (frame_full) state_d = SMID_DONE;
			end
			SMID_DONE: if (cs_rise) state_d = SMID_IDLE;
			default: state_d = SMID_IDLE;
		endcase
	end

	// shifting, snapshot at chip select fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= SMID_IDLE;
			sck_q <= 1'b0;
			cs_n_q <= 1'b1;
			rx_q <= '0;
			tx_q <= '0;
			cnt_q <= '0;
			miso_q <= 1'b0;
		end else begin
			state_q <= state_d;
			sck_q <= sck_s;
			cs_n_q <= cs_n_s;
			if (cs_fall) begin
				cnt_q <= '0;
				tx_q <= answer;
				miso_q <= answer[FRAME_W-1];
			end else if (state_q == SMID_SHIFT) begin
				if (sck_rise) begin
					rx_q <= rx_next;
					cnt_q <= cnt_q + 5'h01;
				end
				// next answer bit leaves on the falling sck edge
				if (sck_fall) begin
					tx_q <= {tx_q[FRAME_W-2:0], 1'b0};
					miso_q <= tx_q[FRAME_W-2];
				end
			end
		end
	end

	// answer for a frame is the one loaded at the next frame start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_cmd_q <= '0;
			reset_seen_n_q <= 1'b0;
		end else begin
			if (frame_full) last_cmd_q <= cmd_ok ? rx_next : '0;
			// reading the flag as zero clears it
			if (cs_fall && is_stat) reset_seen_n_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// apb slave, zero wait states
	// ------------------------------------------------------------
	// pready rises in the access cycle, one cycle after setup, so every
	// transfer is wait-free; unmapped offsets answer with pslverr
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire hit_st = paddr == ADDR_IRQ_STATUS;
	wire hit_mk = paddr == ADDR_IRQ_MASK;
	wire hit_lc = paddr == ADDR_LAST_CMD;
	wire hit_cs = paddr == ADDR_CUR_STATE;
	wire mapped = hit_st | hit_mk | hit_lc | hit_cs;
	// a parity failure hides the command check, so one bad frame raises
	// one error bit only
	wire [IRQ_W-1:0] ev;
	assign ev[IRQ_FRAME] = frame_full;
	assign ev[IRQ_PARITY] = frame_full & ~par_ok;
	assign ev[IRQ_BADCMD] = frame_full & par_ok & ~(id_ok | st_ok);
	wire [IRQ_W-1:0] clr = (wr & hit_st) ? pwdata[IRQ_W-1:0] : '0;
	wire [31:0] rd_mux = hit_st ? {29'h0, irq_st_q} :
		hit_mk ? {29'h0, irq_mask_q} :
		hit_lc ? {16'h0000, last_cmd_q} :
		hit_cs ? {25'h0, reset_seen_n_q, fire_s, 4'(cur_s)} : 32'h0;

	// set wins over a write-one clear in the same cycle
	// irq follows the next status value, so it moves at the same edge
	// as the status bits that it reflects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_st_q <= '0;
			irq_mask_q <= '0;
			irq <= 1'b0;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			irq_st_q <= (irq_st_q & ~clr) | ev;
			if (wr && hit_mk) irq_mask_q <= pwdata[IRQ_W-1:0];
			irq <= |(((irq_st_q & ~clr) | ev) & irq_mask_q);
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0;
		end
	end

	// miso is a flop output, so it changes only on a pclk edge, well
	// clear of the host's sampling sck edge
	assign spi_miso = miso_q;
endmodule // smid_top
`default_nettype wire

// >>> smid_pkg.sv
package smid_pkg;
	// ------------------------------------------------------------
	// frame layout
	// ------------------------------------------------------------
	localparam int FRAME_W = 16;
	localparam int BIT_MODE_HI = 15;
	localparam int BIT_MODE_LO = 14;
	localparam int BIT_PARITY = 13;
	localparam int BIT_CLR = 12;
	localparam int BIT_SEL_HI = 11;
	localparam int BIT_SEL_LO = 10;
	localparam int BIT_TYPE_SEL = 9;
	localparam int BIT_RESET_SEEN = 8;
	localparam int CHANNELS = 4;
	localparam logic [1:0] MON_STATUS = 2'h2;
	localparam logic [1:0] MON_IDENT = 2'h3;
	localparam logic [FRAME_W-1:0] ERR_FRAME = 16'hD000;
	localparam logic [3:0] DEVICE_CODE = 4'h5; // arbitrary value
	localparam logic [5:0] REVISION = 6'h01; // arbitrary value
	// ------------------------------------------------------------
	// apb register map
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h000;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h004;
	localparam logic [11:0] ADDR_LAST_CMD = 12'h008;
	localparam logic [11:0] ADDR_CUR_STATE = 12'h00C;
	localparam int IRQ_W = 3;
	localparam int IRQ_FRAME = 0;
	localparam int IRQ_PARITY = 1;
	localparam int IRQ_BADCMD = 2;
	typedef enum logic [1:0] {
		SMID_IDLE = 2'h0,
		SMID_SHIFT = 2'h1,
		SMID_DONE = 2'h3
	} smid_state_type;
	// odd parity over a frame holding its parity slot
	function automatic logic smid_odd_ok(input logic [FRAME_W-1:0] f);
		return ^f;
	endfunction
endpackage

// >>> smid_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two flop synchroniser for pins
module smid_sync #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	// first stage is read by the second only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // smid_sync
`default_nettype wire

// >>> smid_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// answer frame watcher
// ----
module smid_checker
	import smid_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_miso,
	input wire logic [CHANNELS-1:0] current_threshold,
	input wire logic [1:0] fire_permit
);
	logic sck_q, cs_q, seen_q;
	logic [4:0] cnt_q;
	logic [15:0] sh_q;
	logic [3:0] cur_q;
	logic [1:0] fp_q;
	wire logic done, st, id;
	wire logic rise;
	// a whole answer ends when chip select rises after 16 bits
	assign rise = spi_sck && !sck_q;
	assign done = !cs_q && spi_cs_n && cnt_q == 5'h10;
	// the parity slot D13 is left out of the header match
	assign st = done
		&& {sh_q[15:14], sh_q[12:10]} == {2'h3, 1'b0, MON_STATUS};
	assign id = done
		&& {sh_q[15:14], sh_q[12:10]} == {2'h3, 1'b0, MON_IDENT};
	// raw pins sampled, as the host sees them on sck rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{sck_q, cs_q, seen_q, cnt_q, sh_q, cur_q, fp_q} <= 30'h10000000;
		end else begin
			sck_q <= spi_sck;
			cs_q <= spi_cs_n;
			cnt_q <= spi_cs_n ? 5'h00 : cnt_q + 5'(rise);
			if (rise) sh_q <= {sh_q[14:0], spi_miso};
			if (!spi_cs_n && cs_q) begin
				cur_q <= current_threshold;
				fp_q <= fire_permit;
			end
			if (st) seen_q <= 1'b1;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_resp_parity: assert property (done |-> ^sh_q)
		else $error("answer with even parity");
	a_cur_upper: assert property (st && !sh_q[9] |-> sh_q[7:4] == 4'h0)
		else $error("current status upper nibble not zero");
	a_cur_flags: assert property (st && !sh_q[9] |-> sh_q[3:0] == cur_q)
		else $error("current flags differ from frame start");
	a_fire_upper: assert property (st && sh_q[9] |-> sh_q[7:2] == 6'h00)
		else $error("permit status upper bits not zero");
	a_fire_flags: assert property (st && sh_q[9] |-> sh_q[1:0] == fp_q)
		else $error("permit flags differ from frame start");
	a_ident_body: assert property (id |-> sh_q[9:0] == {DEVICE_CODE, REVISION})
		else $error("identity body wrong");
	a_reset_seen: assert property (st |-> sh_q[8] == seen_q)
		else $error("reset seen bit wrong");
endmodule // smid_checker
bind smid_top smid_checker u_smid_checker (.pclk(pclk), .presetn(presetn),
	.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
	.current_threshold(current_threshold), .fire_permit(fire_permit));
`default_nettype wire

// >>> smid_spi_host.sv
`timescale 1ns/100ps
`default_nettype none
// mode 0 host, msb first; sck stands low between frames
module smid_spi_host (
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_mosi,
	input wire logic spi_miso
);
	initial {spi_sck, spi_cs_n, spi_mosi} = 3'b010;
	// odd start offset keeps sck unrelated in phase to pclk
	task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
		#17 spi_cs_n = 1'b0;
		#400;
		for (int i = 15; i >= 0; i--) begin
			spi_mosi = cmd[i];
			#400 spi_sck = 1'b1;
			rsp[i] = spi_miso;
			#400 spi_sck = 1'b0;
		end
		#400 spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi;
		#400;
	endtask
endmodule // smid_spi_host
`default_nettype wire

// >>> smid_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module smid_top_tb
	import smid_pkg::*;
;
	typedef struct packed {
		logic [15:0] cmd;
		logic [3:0] cur;
		logic [1:0] fp;
		logic [15:0] rsp;
	} smid_row_type;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
	logic sck, cs_n, mosi, miso;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] cur;
	logic [1:0] fp;
	logic [15:0] a;
	int err_total, checks_done;
	// each answer belongs to the command of the row before
	smid_row_type rows [6] = '{
		'{16'hC800, 4'hA, 2'h0, 16'hD000},
		'{16'hEA00, 4'h5, 2'h0, 16'hC805},
		'{16'hEC00, 4'h3, 2'h2, 16'hEB02},
		'{16'hE800, 4'h0, 2'h0, 16'hCD41},
		'{16'hC800, 4'h0, 2'h0, 16'hD000},
		'{16'hC800, 4'hF, 2'h1, 16'hE90F}};
	smid_top u_smid_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
		.current_threshold(cur), .fire_permit(fp));
	smid_spi_host u_smid_spi_host (.spi_sck(sck), .spi_cs_n(cs_n),
		.spi_mosi(mosi), .spi_miso(miso));
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			err_total++;
			$display("unexpected %s exp %h seen %h", nm, x, s);
		end
	endtask
	task conclude;
		if (err_total == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// apb master: request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] ad,
		input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic frame(input logic [15:0] c, input logic [15:0] x);
		u_smid_spi_host.xfer(c, a);
		chk("answer", 32'(a), 32'(x));
	endtask
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		#2000000;
		err_total++;
		conclude;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, cur, fp} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// current flags flip mid-frame: the answer must keep the frame-start value
		for (int i = 0; i < 6; i++) begin
			@(posedge pclk);
			cur <= rows[i].cur;
			fp <= rows[i].fp;
			fork
				u_smid_spi_host.xfer(rows[i].cmd, a);
				begin
					repeat (30) @(posedge pclk);
					cur <= ~rows[i].cur;
				end
			join
			chk("answer", 32'(a), 32'(rows[i].rsp));
		end
		apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
		chk("status", r & 32'h7, 32'h3);
		apb(1'b1, ADDR_IRQ_MASK, 32'h7);
		repeat (2) @(posedge pclk);
		chk("irq", 32'(irq), 32'h1);
		apb(1'b1, ADDR_IRQ_STATUS, 32'h7);
		repeat (2) @(posedge pclk);
		chk("irq", 32'(irq), 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped", {r[30:0], e}, 32'h1);
		apb(1'b0, ADDR_LAST_CMD, 32'h0);
		chk("last", r, 32'hC800);
		// second reset: reset-seen bit must read 0 again
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		frame(16'hC800, 16'hD000);
		frame(16'hC800, 16'hC800);
		// status header with a stray low bit: good parity, refused command
		frame(16'hE801, 16'hE900);
		frame(16'hC800, 16'hD000);
		apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
		chk("status", r & 32'h7, 32'h5);
		apb(1'b0, ADDR_CUR_STATE, 32'h0);
		chk("state", r, 32'h50);
		conclude;
	end
endmodule // smid_top_tb
`default_nettype wire
